/* File: hw/ssx_pkg.sv */
// Constants shared by the skip and subtract execution block and its flag unit.
// Assumes a single 250 MHz core clock and a byte-addressed Avalon-MM register map.
//
// Contract
// - Increment-skip loads working register with memory byte plus one, memory untouched.
// - Increment-skip skips the next instruction when the incremented result is zero.
// - A taken skip adds two dummy cycles, so the instruction lasts three cycles.
// - Bit-test skip skips when the selected bit of the memory byte is one.
// - Byte-test skip reads the memory byte and writes the same value back.
// - Byte-test skip skips when the memory byte is nonzero, else continues.
// - Subtract-to-working stores working register minus memory byte in working register.
// - Subtract-into-memory writes working register minus memory byte back to memory.
// - Subtractions clear carry on a negative difference, set it otherwise.
// - Subtractions update range error, zero, nibble borrow, carry, compare, chained zero.
package ssx_pkg;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WORK = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CYCLES = 8'h0C;
    localparam logic [7:0] REG_MEM_BASE = 8'h40;

    // Data memory geometry
    localparam int MEM_DEPTH = 16;
    localparam int MEM_AW = 4;

    // Control register fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_BIT_LSB = 4;
    localparam int CTRL_ADDR_LSB = 8;

    // Status register fields
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_SC = 4;
    localparam int FLAG_CZ = 5;
    localparam int STAT_SKIP = 8;
    localparam int STAT_BUSY = 9;
    localparam int NUM_FLAGS = 6;

    // Reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] MEM_RST = 8'h00;

    // Cycle counts of an instruction
    localparam logic [1:0] CYC_PLAIN = 2'h1;
    localparam logic [1:0] CYC_SKIP = 2'h3;

    // Instruction codes
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_INC_SKIP = 3'h1,
        OP_SKIP_BIT = 3'h2,
        OP_SKIP_BYTE = 3'h3,
        OP_SUB_WORK = 3'h4,
        OP_SUB_MEM = 3'h5
    } ssx_op_e;

    // Execution states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_DUMMY1 = 2'h2,
        ST_DUMMY2 = 2'h3
    } ssx_state_e;

endpackage

/* File: hw/ssx_sub_flags.sv */
// Subtractor and status flag generator for the subtract instructions.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/10ps
module ssx_sub_flags (
    // Operands
    input wire logic [7:0] i_minuend,
    input wire logic [7:0] i_subtrahend,
    // Results
    output logic [7:0] o_diff,
    output logic [ssx_pkg::NUM_FLAGS-1:0] o_flags
);
    logic [8:0] wide;
    logic [4:0] low;

    // Nine-bit difference exposes the borrow out of bit 7
    always_comb begin
        wide = {1'b0, i_minuend} - {1'b0, i_subtrahend};
        low = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]};
        o_diff = wide[7:0];
    end

    // Flags from the difference
    always_comb begin
        o_flags = '0;
        o_flags[ssx_pkg::FLAG_C] = ~wide[8];
        o_flags[ssx_pkg::FLAG_AC] = ~low[4];
        o_flags[ssx_pkg::FLAG_Z] = (wide[7:0] == 8'h00);
        o_flags[ssx_pkg::FLAG_OV] = (i_minuend[7] ^ i_subtrahend[7]) & (i_minuend[7] ^ wide[7]);
        o_flags[ssx_pkg::FLAG_SC] = o_flags[ssx_pkg::FLAG_OV] ^ wide[7];
        o_flags[ssx_pkg::FLAG_CZ] = (wide[7:0] == 8'h00);
    end
endmodule

/* File: hw/ssx_core.sv */
// Execution unit for the increment-skip, bit/byte skip and subtract instructions.
// Software issues one instruction at a time through an Avalon-MM slave on i_clk.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
module ssx_core (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Sequencer status
    output logic o_busy,
    output logic o_done,
    output logic o_skip
);
    ssx_pkg::ssx_state_e state_q;
    ssx_pkg::ssx_op_e op_q;
    logic [2:0] bit_q;
    logic [ssx_pkg::MEM_AW-1:0] addr_q;
    logic [7:0] work_q;
    logic [ssx_pkg::NUM_FLAGS-1:0] flags_q;
    logic skip_last_q;
    logic [1:0] cycles_q;
    logic [7:0] mem_q [ssx_pkg::MEM_DEPTH];
    logic ack_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic busy_q;
    logic done_q;
    logic skip_q;

    logic req;
    logic can_ack;
    logic take;
    logic wr_take;
    logic in_mem;
    logic [ssx_pkg::MEM_AW-1:0] bus_idx;
    logic start;
    logic exec;
    logic [7:0] mem_rd;
    logic [7:0] inc_val;
    logic skip_now;
    logic exec_we;
    logic [7:0] exec_wdata;
    logic [7:0] diff;
    logic [ssx_pkg::NUM_FLAGS-1:0] sub_flags;
    logic is_sub;

    // Bus decode; writes wait while an instruction runs
    always_comb begin
        req = i_avs_read | i_avs_write;
        can_ack = i_avs_read | ~busy_q;
        take = ack_q & req;
        wr_take = take & i_avs_write & i_avs_byteenable[0];
        in_mem = (i_avs_address[7:6] == ssx_pkg::REG_MEM_BASE[7:6]);
        bus_idx = i_avs_address[ssx_pkg::MEM_AW+1:2];
        start = wr_take & ~busy_q & (i_avs_address == ssx_pkg::REG_CTRL);
        exec = (state_q == ssx_pkg::ST_EXEC);
    end

    // Handshake: one wait cycle, then a single ready cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
            wait_q <= 1'b1;
        end else begin
            ack_q <= req & can_ack & ~ack_q;
            wait_q <= ~(req & can_ack & ~ack_q);
        end
    end

    // Read data prepared while the wait cycle runs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_avs_read & ~ack_q) begin
            rdata_q <= 32'h0000_0000;
            if (in_mem) begin
                rdata_q[7:0] <= mem_q[bus_idx];
            end else begin
                case (i_avs_address)
                    ssx_pkg::REG_CTRL: begin
                        rdata_q[ssx_pkg::CTRL_OP_LSB +: 3] <= op_q;
                        rdata_q[ssx_pkg::CTRL_BIT_LSB +: 3] <= bit_q;
                        rdata_q[ssx_pkg::CTRL_ADDR_LSB +: ssx_pkg::MEM_AW] <= addr_q;
                    end
                    ssx_pkg::REG_WORK: rdata_q[7:0] <= work_q;
                    ssx_pkg::REG_STATUS: begin
                        rdata_q[ssx_pkg::NUM_FLAGS-1:0] <= flags_q;
                        rdata_q[ssx_pkg::STAT_SKIP] <= skip_last_q;
                        rdata_q[ssx_pkg::STAT_BUSY] <= busy_q;
                    end
                    ssx_pkg::REG_CYCLES: rdata_q[1:0] <= cycles_q;
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Latch the instruction fields on a control write
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            op_q <= ssx_pkg::OP_NONE;
            bit_q <= 3'h0;
            addr_q <= '0;
        end else if (start) begin
            op_q <= ssx_pkg::ssx_op_e'(i_avs_writedata[ssx_pkg::CTRL_OP_LSB +: 3]);
            bit_q <= i_avs_writedata[ssx_pkg::CTRL_BIT_LSB +: 3];
            addr_q <= i_avs_writedata[ssx_pkg::CTRL_ADDR_LSB +: ssx_pkg::MEM_AW];
        end
    end

    // Shared subtractor and flag unit
    ssx_sub_flags u_sub (
        .i_minuend(work_q),
        .i_subtrahend(mem_rd),
        .o_diff(diff),
        .o_flags(sub_flags)
    );

    // Operand fetch and per-instruction decisions
    always_comb begin
        mem_rd = mem_q[addr_q];
        inc_val = mem_rd + 8'h01;
        is_sub = (op_q == ssx_pkg::OP_SUB_WORK) | (op_q == ssx_pkg::OP_SUB_MEM);
        skip_now = 1'b0;
        exec_we = 1'b0;
        exec_wdata = mem_rd;
        case (op_q)
            ssx_pkg::OP_INC_SKIP: skip_now = (inc_val == 8'h00);
            ssx_pkg::OP_SKIP_BIT: skip_now = mem_rd[bit_q];
            ssx_pkg::OP_SKIP_BYTE: begin
                skip_now = (mem_rd != 8'h00);
                exec_we = exec;
            end
            ssx_pkg::OP_SUB_MEM: begin
                exec_we = exec;
                exec_wdata = diff;
            end
            default: skip_now = 1'b0;
        endcase
    end

    // Sequencer: one execute cycle, two more when a skip is taken
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ssx_pkg::ST_IDLE;
        end else begin
            case (state_q)
                ssx_pkg::ST_IDLE: if (start) state_q <= ssx_pkg::ST_EXEC;
                ssx_pkg::ST_EXEC: state_q <= skip_now ? ssx_pkg::ST_DUMMY1 : ssx_pkg::ST_IDLE;
                ssx_pkg::ST_DUMMY1: state_q <= ssx_pkg::ST_DUMMY2;
                ssx_pkg::ST_DUMMY2: state_q <= ssx_pkg::ST_IDLE;
                default: state_q <= ssx_pkg::ST_IDLE;
            endcase
        end
    end

    // Busy, completion pulse and skip indication
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            done_q <= (exec & ~skip_now) | (state_q == ssx_pkg::ST_DUMMY2);
            if (start) begin
                busy_q <= 1'b1;
                skip_q <= 1'b0;
            end else if ((exec & ~skip_now) | (state_q == ssx_pkg::ST_DUMMY2)) begin
                busy_q <= 1'b0;
            end
            if (exec) begin
                skip_q <= skip_now;
            end
        end
    end

    // Last instruction's skip result and cycle count
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            skip_last_q <= 1'b0;
            cycles_q <= 2'h0;
        end else if (exec) begin
            skip_last_q <= skip_now;
            cycles_q <= skip_now ? ssx_pkg::CYC_SKIP : ssx_pkg::CYC_PLAIN;
        end
    end

    // Working register: bus writes when idle, results when executing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            work_q <= ssx_pkg::WORK_RST;
        end else if (exec & (op_q == ssx_pkg::OP_INC_SKIP)) begin
            work_q <= inc_val;
        end else if (exec & (op_q == ssx_pkg::OP_SUB_WORK)) begin
            work_q <= diff;
        end else if (wr_take & (i_avs_address == ssx_pkg::REG_WORK)) begin
            work_q <= i_avs_writedata[7:0];
        end
    end

    // Status flags: subtract results, else software writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_q <= ssx_pkg::FLAGS_RST;
        end else if (exec & is_sub) begin
            flags_q <= sub_flags;
        end else if (wr_take & (i_avs_address == ssx_pkg::REG_STATUS)) begin
            flags_q <= i_avs_writedata[ssx_pkg::NUM_FLAGS-1:0];
        end
    end

    // Data memory, one flip-flop byte per entry
    for (genvar g = 0; g < ssx_pkg::MEM_DEPTH; g++) begin : g_mem
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                mem_q[g] <= ssx_pkg::MEM_RST;
            end else if (exec_we & (int'(addr_q) == g)) begin
                mem_q[g] <= exec_wdata;
            end else if (wr_take & in_mem & (int'(bus_idx) == g)) begin
                mem_q[g] <= i_avs_writedata[7:0];
            end
        end
    end

    // Outputs straight from flip-flops
    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_skip = skip_q;

    // Checks on the execution behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    property p_inc_work;
        exec && op_q == ssx_pkg::OP_INC_SKIP |=> work_q == $past(inc_val) && mem_q[addr_q] == $past(mem_rd);
    endproperty
    a_inc_work: assert property (p_inc_work) else $error("increment result wrong or memory changed");

    property p_inc_skip;
        exec && op_q == ssx_pkg::OP_INC_SKIP |-> skip_now == (mem_rd == 8'hFF);
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment skip decision wrong");

    property p_three_cycles;
        exec && skip_now |=> state_q == ssx_pkg::ST_DUMMY1 ##1 state_q == ssx_pkg::ST_DUMMY2
            ##1 (o_done && o_skip && !o_busy && cycles_q == ssx_pkg::CYC_SKIP);
    endproperty
    a_three_cycles: assert property (p_three_cycles) else $error("taken skip not three cycles");

    property p_plain_one;
        exec && !skip_now |=> o_done && !o_busy && state_q == ssx_pkg::ST_IDLE;
    endproperty
    a_plain_one: assert property (p_plain_one) else $error("untaken instruction not one cycle");

    property p_bit_skip;
        exec && op_q == ssx_pkg::OP_SKIP_BIT |-> skip_now == mem_rd[bit_q] && !exec_we;
    endproperty
    a_bit_skip: assert property (p_bit_skip) else $error("bit test skip wrong");

    property p_byte_wb;
        exec && op_q == ssx_pkg::OP_SKIP_BYTE |-> exec_we && exec_wdata == mem_rd;
    endproperty
    a_byte_wb: assert property (p_byte_wb) else $error("byte test write-back missing");

    property p_byte_skip;
        exec && op_q == ssx_pkg::OP_SKIP_BYTE |=> skip_last_q == ($past(mem_rd) != 8'h00);
    endproperty
    a_byte_skip: assert property (p_byte_skip) else $error("byte test skip wrong");

    property p_sub_work;
        exec && op_q == ssx_pkg::OP_SUB_WORK |=> work_q == $past(work_q) - $past(mem_rd);
    endproperty
    a_sub_work: assert property (p_sub_work) else $error("subtract to working wrong");

    property p_sub_mem;
        exec && op_q == ssx_pkg::OP_SUB_MEM |=> mem_q[addr_q] == $past(work_q) - $past(mem_rd)
            && work_q == $past(work_q);
    endproperty
    a_sub_mem: assert property (p_sub_mem) else $error("subtract into memory wrong");

    property p_sub_carry;
        exec && is_sub |=> flags_q[ssx_pkg::FLAG_C] == ($past(work_q) >= $past(mem_rd));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("carry after subtract wrong");

    property p_sub_flags;
        exec && is_sub |=> flags_q[ssx_pkg::FLAG_Z] == ($past(work_q) == $past(mem_rd))
            && flags_q[ssx_pkg::FLAG_CZ] == flags_q[ssx_pkg::FLAG_Z]
            && flags_q[ssx_pkg::FLAG_AC] == ($past(work_q[3:0]) >= $past(mem_rd[3:0]));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

    property p_inc_wrap;
        exec && op_q == ssx_pkg::OP_INC_SKIP && mem_rd == 8'hFF |=> work_q == 8'h00 && skip_last_q;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment does not wrap");

    // Signed compare flag is the signed less-than of the operands
    property p_sub_sc;
        exec && is_sub |=> flags_q[ssx_pkg::FLAG_SC] == ($signed($past(work_q)) < $signed($past(mem_rd)));
    endproperty
    a_sub_sc: assert property (p_sub_sc) else $error("signed compare flag wrong");

    // Range error: operand signs differ and the result sign differs from the minuend
    property p_sub_ovf;
        exec && is_sub |=> flags_q[ssx_pkg::FLAG_OV] == (($past(work_q[7]) != $past(mem_rd[7]))
            && ($past(work_q[7]) != (($past(work_q) - $past(mem_rd)) >= 8'h80)));
    endproperty
    a_sub_ovf: assert property (p_sub_ovf) else $error("range error flag wrong");

    property p_inc_nowr;
        exec && op_q == ssx_pkg::OP_INC_SKIP |-> !exec_we;
    endproperty
    a_inc_nowr: assert property (p_inc_nowr) else $error("increment wrote data memory");

    property p_bit_keep;
        exec && op_q == ssx_pkg::OP_SKIP_BIT |=> mem_q[addr_q] == $past(mem_rd) && work_q == $past(work_q);
    endproperty
    a_bit_keep: assert property (p_bit_keep) else $error("bit test changed state");

    property p_byte_keep;
        exec && op_q == ssx_pkg::OP_SKIP_BYTE |=> mem_q[addr_q] == $past(mem_rd) && work_q == $past(work_q);
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte test changed memory value");

    property p_start_busy;
        start |=> o_busy && state_q == ssx_pkg::ST_EXEC;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not enter execute");

    // Writes are held off for the whole instruction
    property p_no_write_busy;
        busy_q |-> !wr_take;
    endproperty
    a_no_write_busy: assert property (p_no_write_busy) else $error("write accepted while busy");

    // Ready lasts exactly one cycle
    property p_wait_one;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");

endmodule

/* File: bench/ssx_core_tb.sv */
// Self-checking bench for the skip and subtract execution unit.
// Drives the Avalon-MM slave directly and keeps a reference copy of the work register, flags and memory.
`timescale 1ns/10ps
module ssx_core_tb;
    // Design inputs and outputs
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_avs_address = 8'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic o_busy;
    logic o_done;
    logic o_skip;
    // Expected results and reference state
    logic [31:0] exp_q[$];
    logic skip_q[$];
    logic [7:0] mem_m [ssx_pkg::MEM_DEPTH];
    logic [7:0] work_m = 8'h00;
    logic [5:0] flags_m = 6'h00;
    logic skip_m = 1'b0;
    logic [1:0] cyc_m = 2'h0;
    int n_mismatch = 0;
    int comparisons = 0;
    // Each entry packs op, bit index, address, memory value and work value
    localparam logic [31:0] TBL [15] = '{32'h010FFF00, 32'h01037F12, 32'h02728000, 32'h02727F00,
        32'h02000100, 32'h030500AA, 32'h030501AA, 32'h04010605, 32'h04013333, 32'h04010180,
        32'h04010110, 32'h0506FF7F, 32'h05060000, 32'h00000000, 32'h07040000};

    ssx_core i_dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .o_busy(o_busy),
        .o_done(o_done),
        .o_skip(o_skip)
    );

    // Free-running core clock
    initial begin
        forever #2 i_clk = ~i_clk;
    end

    // Verdict and end of run
    task automatic stop_test;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic fail_msg(input string msg);
        n_mismatch++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    // Hold the request until waitrequest is sampled low, bounded
    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 100);
        if (o_avs_waitrequest !== 1'b0) begin
            fail_msg("bus request never acknowledged");
            stop_test();
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        i_avs_write <= 1'b1;
        wait_ack();
        i_avs_write <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_read <= 1'b1;
        wait_ack();
        i_avs_read <= 1'b0;
    endtask

    // Read data checker: takes the oldest note at each accepted read
    always @(posedge i_clk) begin
        if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
            comparisons++;
            if (exp_q.size() == 0) begin
                fail_msg("unexpected read");
            end else begin
                if (o_avs_readdata !== exp_q[0]) begin
                    fail_msg($sformatf("addr %h read %h expected %h", i_avs_address, o_avs_readdata, exp_q[0]));
                end
                void'(exp_q.pop_front());
            end
        end
    end

    // Skip result checker at each completion pulse
    always @(posedge i_clk) begin
        if (o_done === 1'b1) begin
            comparisons++;
            if (skip_q.size() == 0) begin
                fail_msg("unexpected done pulse");
            end else begin
                if (o_skip !== skip_q[0]) begin
                    fail_msg("skip outcome");
                end
                if (o_busy !== 1'b0) begin
                    fail_msg("busy still set at done");
                end
                void'(skip_q.pop_front());
            end
        end
    end

    // Reference model of one instruction
    task automatic model(input logic [2:0] op, input logic [2:0] bi, input logic [3:0] ad);
        logic [7:0] m;
        logic [7:0] d;
        m = mem_m[ad];
        d = work_m - m;
        skip_m = 1'b0;
        case (op)
            ssx_pkg::OP_INC_SKIP: begin
                work_m = m + 8'h01;
                skip_m = (work_m == 8'h00);
            end
            ssx_pkg::OP_SKIP_BIT: skip_m = m[bi];
            ssx_pkg::OP_SKIP_BYTE: skip_m = (m != 8'h00);
            ssx_pkg::OP_SUB_WORK, ssx_pkg::OP_SUB_MEM: begin
                flags_m[ssx_pkg::FLAG_C] = (work_m >= m);
                flags_m[ssx_pkg::FLAG_AC] = (work_m[3:0] >= m[3:0]);
                flags_m[ssx_pkg::FLAG_Z] = (d == 8'h00);
                flags_m[ssx_pkg::FLAG_OV] = (work_m[7] != m[7]) && (d[7] != work_m[7]);
                flags_m[ssx_pkg::FLAG_SC] = flags_m[ssx_pkg::FLAG_OV] ^ d[7];
                flags_m[ssx_pkg::FLAG_CZ] = (d == 8'h00);
                if (op == ssx_pkg::OP_SUB_WORK) begin
                    work_m = d;
                end else begin
                    mem_m[ad] = d;
                end
            end
            default: ;
        endcase
        cyc_m = skip_m ? ssx_pkg::CYC_SKIP : ssx_pkg::CYC_PLAIN;
    endtask

    // Load operands, run one instruction, then read back every result
    task automatic run_op(input logic [2:0] op, input logic [2:0] bi, input logic [3:0] ad,
                          input logic [7:0] mv, input logic [7:0] wv);
        int n;
        logic [7:0] ma;
        logic [31:0] ctrl;
        ma = ssx_pkg::REG_MEM_BASE + {2'h0, ad, 2'h0};
        ctrl = {20'h00000, ad, 1'b0, bi, 1'b0, op};
        bus_write(ma, {24'hFFFFFF, mv}, 4'hF);
        bus_write(ssx_pkg::REG_WORK, {24'h000000, wv}, 4'hF);
        mem_m[ad] = mv;
        work_m = wv;
        model(op, bi, ad);
        skip_q.push_back(skip_m);
        bus_write(ssx_pkg::REG_CTRL, ctrl, 4'hF);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
            if (n == 1 && o_busy !== 1'b1) begin
                fail_msg("busy not raised after start");
            end
        end while (o_done !== 1'b1 && n < 20);
        comparisons++;
        if (o_done !== 1'b1) begin
            fail_msg("instruction never completed");
            stop_test();
        end else if (n != int'(cyc_m) + 1) begin
            fail_msg("instruction length");
        end
        bus_read(ssx_pkg::REG_WORK, {24'h000000, work_m});
        bus_read(ma, {24'h000000, mem_m[ad]});
        bus_read(ssx_pkg::REG_STATUS, {22'h000000, 1'b0, skip_m, 2'h0, flags_m});
        bus_read(ssx_pkg::REG_CYCLES, {30'h00000000, cyc_m});
        bus_read(ssx_pkg::REG_CTRL, ctrl);
    endtask

    // Main sequence
    initial begin
        foreach (mem_m[k]) begin
            mem_m[k] = ssx_pkg::MEM_RST;
        end
        void'($urandom(11));
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        // Reset values, unmapped address and a lane-0-disabled write
        bus_read(ssx_pkg::REG_WORK, 32'h00000000);
        bus_read(ssx_pkg::REG_STATUS, 32'h00000000);
        bus_read(ssx_pkg::REG_MEM_BASE + 8'h3C, 32'h00000000);
        bus_write(8'h20, 32'hFFFFFFFF, 4'hF);
        bus_read(8'h20, 32'h00000000);
        bus_write(ssx_pkg::REG_WORK, 32'h0000005A, 4'hE);
        bus_read(ssx_pkg::REG_WORK, 32'h00000000);
        // Software flag write; skip and busy bits are read-only
        bus_write(ssx_pkg::REG_STATUS, 32'h0000033F, 4'hF);
        flags_m = 6'h3F;
        bus_read(ssx_pkg::REG_STATUS, 32'h0000003F);
        // Directed boundary cases of every instruction code
        foreach (TBL[k]) begin
            run_op(TBL[k][26:24], TBL[k][22:20], TBL[k][19:16], TBL[k][15:8], TBL[k][7:0]);
        end
        // Random operands and codes
        for (int k = 0; k < 60; k++) begin
            run_op(3'($urandom_range(7)), 3'($urandom), 4'($urandom), 8'($urandom), 8'($urandom));
        end
        // Work register write issued while a skipping instruction runs is held off, not lost
        mem_m[4'h2] = 8'hFF;
        bus_write(ssx_pkg::REG_MEM_BASE + 8'h08, 32'h000000FF, 4'hF);
        model(ssx_pkg::OP_INC_SKIP, 3'h0, 4'h2);
        skip_q.push_back(skip_m);
        bus_write(ssx_pkg::REG_CTRL, 32'h00000201, 4'hF);
        bus_write(ssx_pkg::REG_WORK, 32'h00000011, 4'hF);
        bus_read(ssx_pkg::REG_WORK, 32'h00000011);
        bus_read(ssx_pkg::REG_STATUS, {22'h000000, 1'b0, 1'b1, 2'h0, flags_m});
        repeat (4) @(posedge i_clk);
        // Every noted result must have been seen
        if (exp_q.size() != 0 || skip_q.size() != 0) begin
            fail_msg("expected results never seen");
        end
        stop_test();
    end
endmodule
